// [prio_irq_pkg.sv]
// Summary of operation
// RULE1: Port D7 write loads level and mode
// RULE2: Mode one gives table vectors, zero restarts
// RULE3: Bit 6 selects alternate or main map
// RULE4: Bits 5 and 4 select bus exchange
// RULE5: Bit 3 set removes level restriction
// RULE6: Level 0 none, 8 all, n disables n-7
// RULE7: Active-low lines, level 0 wins
// RULE8: Request only above current held level
// RULE9: Request and vector held in latch
// RULE10: Enabling write clears pending, lines re-request
// RULE11: Software enables controller before processor
// RULE12: Software keeps copy, preserves bits 4-6
// RULE13: Service writes level, restores on exit
// RULE14: Restart byte carries level in bits 5-3
// RULE15: Vector low byte F0 plus twice level
// RULE16: Fixed restart mode jumps to 0038
// RULE17: Non-maskable outranks, cannot disable, 0066
// RULE18: Watchdog raises non-maskable after 10 ms
// RULE19: External bus line raises non-maskable
// RULE20: Software initialises everything after power-up
// RULE21: Reset clears control register to zero
package prio_irq_pkg;
    localparam logic [7:0] CTRL_PORT      = 8'hD7;   // Control port code
    localparam logic [7:0] CTRL_RESET     = 8'h00;   // Control reset value
    localparam int         MODE_BIT       = 7;       // Vector mode flag
    localparam int         MAP_BIT        = 6;       // Address map select
    localparam int         XCHG_HI        = 5;       // Exchange mode high bit
    localparam int         XCHG_LO        = 4;       // Exchange mode low bit
    localparam int         GROUP_BIT      = 3;       // Group select bit
    localparam logic [7:0] RST_OPC_BASE   = 8'hC7;   // Restart opcode, level zero
    localparam logic [7:0] VEC_LOW_BASE   = 8'hF0;   // Table vector low base
    localparam int         CLK_MHZ        = 125;     // Core clock rate
    localparam int         WDOG_MS        = 10;      // Watchdog timeout
    localparam int         WDOG_CYCLES    = WDOG_MS * 1000 * 1000 * CLK_MHZ / 1000;
    // Latched request and vector to the processor
    typedef struct packed {
        logic       req;
        logic [2:0] level;
        logic [7:0] vec;
    } irq_out_t;
endpackage

// [nmi_watchdog.sv]
// Watchdog: counts cycles of an unacknowledged access
module nmi_watchdog
    import prio_irq_pkg::*;
#(
    parameter int LIMIT = WDOG_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic cycle_active,
    input  wire logic cycle_ack,
    output logic      timeout_r
);
    logic [31:0] cnt_r;          // Cycles waiting
    logic [31:0] cnt_nxt;
    logic        timeout_nxt;

    // Count while a cycle waits, clear on acknowledge or idle
    always_comb begin
        cnt_nxt     = 32'h0;
        timeout_nxt = 1'b0;
        if (cycle_active && !cycle_ack) begin
            cnt_nxt     = (cnt_r == LIMIT[31:0]) ? cnt_r : cnt_r + 32'h1;
            timeout_nxt = (cnt_r == LIMIT[31:0] - 32'h1) || (cnt_r == LIMIT[31:0]); // RULE18
        end
    end

    // Register only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r     <= 32'h0;
            timeout_r <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            timeout_r <= timeout_nxt;
        end
    end
endmodule

// [priority_interrupt_vectoring.sv]
// Board priority interrupt controller with vector supply and NMI
//
// One write-only control port carries everything software can set:
// the level field in bits 3 to 0, the exchange mode in bits 5 and 4,
// the address map in bit 6 and the vector mode in bit 7.
// Nothing here can be read back, so software keeps its own copy.
//
// Eight active-low request lines come in with line 0 the most urgent.
// A line counts only while its level is enabled by the level field.
// With the group bit clear, a level value n enables the levels below n.
// With the group bit set, every level is enabled.
// Value zero therefore shuts every maskable level off.
//
// The winning request is latched together with its acknowledge byte.
// The latch holds until the processor acknowledges it or software
// writes the control port, so repeated fetch cycles cannot lose it.
// A control write always empties the latch. A line that is still held
// after such a write latches again on the next cycle if the new word enables it, so no device
// is left waiting behind a cleared request.
//
// The acknowledge byte is a restart opcode in restart mode, the low
// byte of a table vector in vectored mode, and the restart that lands
// on the fixed handler while the processor runs in fixed-restart mode.
//
// The non-maskable request bypasses the level field completely.
// It comes from the access watchdog, from the external line, or both,
// depending on which sources are fitted on this build.
// Power-up state is not relied upon: reset clears the control word.
module priority_interrupt_vectoring
    import prio_irq_pkg::*;
#(
    parameter int  WDOG_LIMIT  = WDOG_CYCLES,
    parameter bit  WDOG_FITTED = 1'b1,
    parameter bit  EXT_FITTED  = 1'b1
) (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       io_wr,          // I/O write strobe, one cycle
    input  wire logic [7:0] io_addr,        // Port code
    input  wire logic [7:0] io_wdata,       // Write data
    input  wire logic [7:0] bus_int_b,      // Active-low requests, bit 0 highest
    input  wire logic       irq_ack,        // Processor acknowledge pulse
    input  wire logic       fixed_mode,     // Processor in fixed-restart mode
    input  wire logic       mem_io_active,  // Access in progress
    input  wire logic       mem_io_ack,     // Access acknowledged
    input  wire logic       ext_nmi_b,      // External non-maskable, active low
    output logic            cpu_int_r,      // Request to processor
    output logic [7:0]      ack_byte_r,     // Byte for acknowledge cycle
    output logic            map_alt_r,      // Alternate address map
    output logic [1:0]      xchg_mode_r,    // Bus exchange mode
    output logic            vec_mode_r,     // Table vector mode
    output logic            cpu_nmi_r       // Non-maskable request
);
    logic [7:0] ctrl_r;        // Write-only control register
    logic [7:0] ctrl_nxt;
    irq_out_t   lat_r;         // Latched request and vector
    irq_out_t   lat_nxt;
    logic       nmi_nxt;
    logic       wd_timeout;
    logic       ctrl_wr;
    logic [7:0] enabled;       // Enabled levels
    logic [7:0] active;        // Asserted enabled requests
    logic       found;
    logic [2:0] win;
    logic [3:0] lvl_n;
    logic [7:0] vec_calc;

    assign ctrl_wr = io_wr && (io_addr == CTRL_PORT); // RULE1

    // Watchdog for unacknowledged accesses
    nmi_watchdog #(
        .LIMIT (WDOG_LIMIT)
    ) u_wdog (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .cycle_active (mem_io_active),
        .cycle_ack    (mem_io_ack),
        .timeout_r    (wd_timeout)
    );

    // Enable mask, priority encoder and vector forming.
    //
    // The mask is worked out per level from the stored control word,
    // never from the write data, so a write takes effect one cycle
    // after it is taken and a request seen in the write cycle is
    // judged against the old mask, then thrown away by the clear.
    //
    // The encoder scans from the least urgent level to the most urgent
    // one and lets every later hit overwrite the earlier one, so the
    // last hit standing is the lowest-numbered asserted enabled line.
    //
    // The byte is formed here for whatever level wins right now; it is
    // only kept when the latch is empty and takes the request.
    always_comb begin
        lvl_n    = ctrl_r[3:0];
        enabled  = 8'h00;
        active   = 8'h00;
        found    = 1'b0;
        win      = 3'h0;
        vec_calc = 8'h00;
        for (int i = 0; i < 8; i++) begin
            // Group bit set: no restriction; else levels below n enabled
            enabled[i] = ctrl_r[GROUP_BIT] || (i < int'(lvl_n)); // RULE5 RULE6
        end
        active = enabled & ~bus_int_b; // RULE7
        for (int i = 7; i >= 0; i--) begin
            if (active[i]) begin
                found = 1'b1; // RULE8
                win   = 3'(i); // RULE7
            end
        end
        if (fixed_mode) begin
            vec_calc = 8'hFF; // RULE16
        end else if (ctrl_r[MODE_BIT]) begin
            vec_calc = VEC_LOW_BASE + {4'h0, win, 1'b0}; // RULE2 RULE15
        end else begin
            vec_calc = RST_OPC_BASE | {2'b00, win, 3'b000}; // RULE2 RULE14
        end
    end

    // Control register and request latch next state.
    //
    // Priority of events inside one cycle:
    //   a control write wins, it loads the word and empties the latch;
    //   otherwise a full latch only waits for the acknowledge;
    //   otherwise an empty latch takes the current winner.
    // A request that arrives while the latch is full is not queued;
    // its line is expected to stay asserted until it is served.
    //
    // The non-maskable request is a plain registered copy of its
    // sources and ignores the level field and the latch entirely.
    always_comb begin
        ctrl_nxt = ctrl_r;
        lat_nxt  = lat_r;
        if (ctrl_wr) begin
            ctrl_nxt    = io_wdata; // RULE1 RULE3 RULE4
            lat_nxt.req = 1'b0; // RULE10
        end else if (lat_r.req) begin
            if (irq_ack) begin
                lat_nxt.req = 1'b0;
            end
        end else if (found) begin
            lat_nxt.req   = 1'b1; // RULE9
            lat_nxt.level = win;
            lat_nxt.vec   = vec_calc;
        end
        nmi_nxt = (WDOG_FITTED && wd_timeout) || (EXT_FITTED && !ext_nmi_b); // RULE17 RULE18 RULE19
    end

    // Register only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r    <= CTRL_RESET; // RULE21
            lat_r     <= '0;
            cpu_nmi_r <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            lat_r     <= lat_nxt;
            cpu_nmi_r <= nmi_nxt;
        end
    end

    // Output flops mirror state.
    //
    // They load the next values rather than the stored ones, so every
    // pin moves on the same edge as the state behind it and still comes
    // straight from a flip-flop. The request pin and the latch therefore
    // always agree, which the checks below rely on.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_int_r   <= 1'b0;
            ack_byte_r  <= 8'h00;
            map_alt_r   <= 1'b0;
            xchg_mode_r <= 2'b00;
            vec_mode_r  <= 1'b0;
        end else begin
            cpu_int_r   <= lat_nxt.req; // RULE9
            ack_byte_r  <= lat_nxt.vec;
            map_alt_r   <= ctrl_nxt[MAP_BIT]; // RULE3
            xchg_mode_r <= ctrl_nxt[XCHG_HI:XCHG_LO]; // RULE4
            vec_mode_r  <= ctrl_nxt[MODE_BIT]; // RULE2
        end
    end

    // Checks.
    //
    // All checks run on the core clock and are quiet during reset.
    // They watch the stored state, the decode signals, the pins and the stimulus inputs,
    // and each one names the rule it guards on its label line.

    // With every level off nothing new may enter the latch
    a_ctrl_zero_off: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE6
        (ctrl_r == 8'h00) |-> !lat_r.req || $past(lat_r.req))
        else $error("request latched with all levels off");
    // A taken control write empties the latch
    a_write_clears: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE10
        ctrl_wr |=> !lat_r.req)
        else $error("control write did not clear pending");
    // A line held through the enabling write asks again at once
    a_rerequest: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE10
        (ctrl_wr && io_wdata == 8'h08 && !bus_int_b[0]) ##1 (!bus_int_b[0] && !ctrl_wr)
        |=> lat_r.req && lat_r.level == 3'h0)
        else $error("held line did not re-request");
    // The latch keeps request and byte until served
    a_latch_hold: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE9
        (lat_r.req && !irq_ack && !ctrl_wr) |=> lat_r.req && $stable(lat_r.vec))
        else $error("latched request lost");
    // Restart mode carries the level in bits 5 to 3
    a_restart_byte: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE14
        (!lat_r.req && found && !ctrl_wr && !ctrl_r[MODE_BIT] && !fixed_mode)
        |=> lat_r.vec == (8'hC7 | {2'b00, lat_r.level, 3'b000}))
        else $error("restart byte wrong");
    // Vectored mode gives the table base plus twice the level
    a_vector_byte: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE15
        (!lat_r.req && found && !ctrl_wr && ctrl_r[MODE_BIT] && !fixed_mode)
        |=> lat_r.vec == 8'hF0 + {4'h0, lat_r.level, 1'b0})
        else $error("vector byte wrong");
    // Fixed-restart mode always lands on the one fixed handler
    a_fixed_byte: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE16
        (!lat_r.req && found && !ctrl_wr && fixed_mode) |=> lat_r.vec == 8'hFF)
        else $error("fixed restart byte wrong");
    // Only a level below the threshold may be latched
    a_level_gate: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE8
        (!lat_r.req && !ctrl_wr && found) |=> int'(lat_r.level) < int'($past(lvl_n))
        || $past(ctrl_r[GROUP_BIT]))
        else $error("request above threshold");
    // Group bit lifts the threshold entirely
    a_group_open: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
        ctrl_r[GROUP_BIT] |-> enabled == 8'hFF)
        else $error("group bit did not open all levels");
    // Level value zero shuts every maskable level
    a_level_none: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE6
        (ctrl_r[3:0] == 4'h0) |-> enabled == 8'h00)
        else $error("levels enabled with value zero");
    // Level value n enables exactly the levels below n
    a_level_mask: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE6
        !ctrl_r[GROUP_BIT] |-> enabled == 8'((9'h001 << lvl_n) - 9'h001))
        else $error("level mask wrong");
    // The winner is asserted and no more urgent line is
    a_win_highest: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
        found |-> active[win] && ((active & ((8'h01 << win) - 8'h01)) == 8'h00))
        else $error("winner is not the most urgent line");
    // No winner means no asserted enabled line
    a_none_found: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
        !found |-> active == 8'h00)
        else $error("asserted line not found");
    // Request and byte pins agree with the latch
    a_int_mirror: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE9
        cpu_int_r == lat_r.req && ack_byte_r == lat_r.vec)
        else $error("request pins differ from latch");
    // An acknowledge empties the latch
    a_ack_drops: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE9
        (lat_r.req && irq_ack) |=> !lat_r.req)
        else $error("acknowledge did not drop request");
    // External line reaches the non-maskable pin
    a_ext_nmi: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE19
        !ext_nmi_b |=> cpu_nmi_r == EXT_FITTED)
        else $error("external nmi not passed");
    // Watchdog timeout reaches the non-maskable pin
    a_nmi_wdog: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE18
        wd_timeout |=> cpu_nmi_r == WDOG_FITTED)
        else $error("watchdog nmi not passed");
    // A control write cannot mask the non-maskable request
    a_nmi_unmasked: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE17
        (ctrl_wr && !ext_nmi_b && EXT_FITTED) |=> cpu_nmi_r)
        else $error("control write masked nmi");
    // No source means no non-maskable request
    a_nmi_quiet: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE17
        (ext_nmi_b && !wd_timeout) |=> !cpu_nmi_r)
        else $error("nmi without a source");
    // Control pins load from the taken write
    a_ctrl_out: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
        ctrl_wr |=> map_alt_r == $past(io_wdata[6]) && xchg_mode_r == $past(io_wdata[5:4])
        && vec_mode_r == $past(io_wdata[7]))
        else $error("control outputs not loaded");
    // Control pins hold between writes
    a_map_hold: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
        !ctrl_wr |=> $stable(map_alt_r) && $stable(xchg_mode_r) && $stable(vec_mode_r))
        else $error("control outputs moved without a write");

    // Main scenarios: served request, vectored request, fixed mode,
    // re-request of a held line, and a non-maskable request
    c_irq: cover property (@(posedge core_clk) disable iff (!rst_b) lat_r.req ##1 irq_ack);
    c_vec: cover property (@(posedge core_clk) disable iff (!rst_b) lat_r.req && ctrl_r[7]);
    c_fix: cover property (@(posedge core_clk) disable iff (!rst_b) lat_r.req && fixed_mode);
    c_again: cover property (@(posedge core_clk) disable iff (!rst_b)
        lat_r.req ##1 !lat_r.req ##1 lat_r.req);
    c_nmi: cover property (@(posedge core_clk) disable iff (!rst_b) cpu_nmi_r);
endmodule

// [cpu_model.sv]
module cpu_model (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       cpu_int_r,
    input  wire logic [7:0] ack_byte_r,
    output logic            irq_ack,
    output logic [7:0]      got_byte,
    output int              got_n
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_n;  // Cycles left before acknowledging
    // Takes a held request after a varying delay, one pulse per request
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ack <= 1'h0;
            got_byte <= 8'h00;
            got_n <= 0;
            wait_n <= 0;
        end else begin
            irq_ack <= 1'h0;
            if (cpu_int_r && !irq_ack) begin
                if (wait_n == 0) begin
                    irq_ack <= 1'h1;
                    got_byte <= ack_byte_r;
                    got_n <= got_n + 1;
                    wait_n <= got_n % 3;
                end else begin
                    wait_n <= wait_n - 1;
                end
            end
        end
    end
endmodule

// [priority_interrupt_vectoring_bench.sv]
module priority_interrupt_vectoring_bench;
    import prio_irq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst_b, io_wr, irq_ack, fixed_mode, mem_io_active, mem_io_ack, ext_nmi_b;
    logic cpu_int_r, map_alt_r, vec_mode_r, cpu_nmi_r;
    logic [1:0] xchg_mode_r;
    logic [7:0] io_addr, io_wdata, bus_int_b, ack_byte_r, got_byte, ctrl;
    logic [31:0] seed;
    logic [7:0] cc [5] = '{8'h08, 8'h00, 8'h87, 8'h01, 8'h88};  // Corner controls
    logic [7:0] cl [5] = '{8'h00, 8'h00, 8'hFE, 8'h00, 8'h7F};  // Corner lines
    int fail_count, compares, got_n, n0, lvl;
    priority_interrupt_vectoring #(.WDOG_LIMIT(20)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata), .bus_int_b(bus_int_b),
        .irq_ack(irq_ack), .fixed_mode(fixed_mode), .mem_io_active(mem_io_active),
        .mem_io_ack(mem_io_ack), .ext_nmi_b(ext_nmi_b), .cpu_int_r(cpu_int_r),
        .ack_byte_r(ack_byte_r), .map_alt_r(map_alt_r), .xchg_mode_r(xchg_mode_r),
        .vec_mode_r(vec_mode_r), .cpu_nmi_r(cpu_nmi_r));
    cpu_model u_cpu (.core_clk(core_clk), .rst_b(rst_b), .cpu_int_r(cpu_int_r),
        .ack_byte_r(ack_byte_r), .irq_ack(irq_ack), .got_byte(got_byte), .got_n(got_n));
    // Clock
    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Winning level, 8 when nothing enabled is asserted
    function automatic int win(input logic [7:0] c, input logic [7:0] l);
        for (int i = 0; i < 8; i++) if (!l[i] && (c[3] || i < c[2:0])) return i;
        return 8;
    endfunction
    function automatic logic [7:0] exp_byte(input logic [7:0] c, input logic f, input int v);
        return f ? 8'hFF : (c[7] ? 8'hF0 + 8'(2 * v) : 8'hC7 | 8'(v << 3));
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One port write, then an idle edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        io_wr <= 1'h1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge core_clk);
        io_wr <= 1'h0;
        @(posedge core_clk);
    endtask
    task automatic close_out();
        if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100us;
        fail_count++;
        close_out();
    end
    initial begin
        {rst_b, io_wr, fixed_mode, mem_io_active, mem_io_ack} = 5'h00;
        {io_addr, io_wdata, ext_nmi_b, bus_int_b} = {16'h0000, 1'h1, 8'hFF};
        seed = 32'h519D;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'h1;
        @(posedge core_clk);
        #1 chk({3'h0, cpu_int_r, map_alt_r, xchg_mode_r, vec_mode_r}, 8'h00);
        for (int it = 0; it < 60; it++) begin
            seed = xs(seed);
            ctrl = (it < 5) ? cc[it] : seed[7:0];
            @(posedge core_clk);
            bus_int_b <= (it < 5) ? cl[it] : seed[15:8];
            fixed_mode <= (it < 5) ? 1'h0 : seed[16];
            lvl = win(ctrl, (it < 5) ? cl[it] : seed[15:8]);
            @(posedge core_clk);
            n0 = got_n;
            wr(8'hD7, ctrl);
            #1 chk({vec_mode_r, map_alt_r, xchg_mode_r, 4'h0}, {ctrl[7:4], 4'h0});
            // First acknowledge after the enabling write, second from the held line
            for (int rep = 0; rep < 2; rep++) begin
                for (int k = 0; k < 14 && got_n == n0; k++) @(posedge core_clk);
                #1 chk(8'(got_n != n0), 8'(lvl < 8));
                if (got_n != n0) chk(got_byte, exp_byte(ctrl, fixed_mode, lvl));
                n0 = got_n;
            end
            @(posedge core_clk);
            bus_int_b <= 8'hFF;
            wr(8'hD7, 8'h00);
        end
        @(posedge core_clk);
        wr(8'hD6, 8'hFF);
        #1 chk({vec_mode_r, map_alt_r, xchg_mode_r, cpu_nmi_r}, 8'h00);
        @(posedge core_clk);
        mem_io_active <= 1'h1;
        repeat (10) @(posedge core_clk);
        mem_io_ack <= 1'h1;
        @(posedge core_clk);
        {mem_io_active, mem_io_ack} <= 2'h0;
        repeat (30) @(posedge core_clk);
        #1 chk(8'(cpu_nmi_r), 8'h00);
        @(posedge core_clk);
        mem_io_active <= 1'h1;
        repeat (25) @(posedge core_clk);
        #1 chk(8'(cpu_nmi_r), 8'h01);
        @(posedge core_clk);
        mem_io_active <= 1'h0;
        rst_b <= 1'h0;
        @(posedge core_clk);
        #1 chk({3'h0, cpu_int_r, map_alt_r, xchg_mode_r, cpu_nmi_r}, 8'h00);
        @(posedge core_clk);
        rst_b <= 1'h1;
        @(posedge core_clk);
        ext_nmi_b <= 1'h0;
        repeat (2) @(posedge core_clk);
        #1 chk(8'(cpu_nmi_r), 8'h01);
        close_out();
    end
endmodule
